// ### hdl/mslc_defs.svh
// Constants of the monitor run/freeze control block: offsets, fields, resets, timing.
// Assumes a 125 MHz clock and a byte-addressed AXI4-Lite register space.
`ifndef MSLC_DEFS_SVH
`define MSLC_DEFS_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define MSLC_ADDR_W 8
`define MSLC_OFS_DUTY0 8'h30
`define MSLC_OFS_DUTY_STEP 8'h04
`define MSLC_OFS_CTRL 8'h40
`define MSLC_OFS_FAN_MODE 8'h80
`define MSLC_OFS_LIMIT0 8'h84
`define MSLC_OFS_LIMIT_STEP 8'h04
`define MSLC_OFS_STATUS 8'ha0
`define MSLC_OFS_EVENT 8'ha4
`define MSLC_OFS_READING 8'ha8
`define MSLC_OFS_TACH 8'hac

// ----------------------------------------------------------------------------
// Control register fields and reset values
// ----------------------------------------------------------------------------
`define MSLC_RUN_BIT 0
`define MSLC_FREEZE_BIT 1
`define MSLC_READY_BIT 2
`define MSLC_OVR_BIT 3
`define MSLC_CTRL_RESET 8'h00
`define MSLC_FULL_DUTY 8'hff
`define MSLC_LIMIT_DEFAULT 8'h7f
`define MSLC_FAN_MODE_RESET 3'h0
`define MSLC_NUM_FANS 3
`define MSLC_NUM_LIMITS 4
`define MSLC_NUM_EVENTS 4
`define MSLC_RESP_OKAY 2'b00
`define MSLC_RESP_SLVERR 2'b10

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define MSLC_CLK_PERIOD_NS 8
`define MSLC_STARTUP_MS 82
`define MSLC_STARTUP_CYC ((`MSLC_STARTUP_MS * 1000000) / `MSLC_CLK_PERIOD_NS)

`endif

// ### hdl/mslc_pkg.sv
// Types shared by the monitor run/freeze control block.
// Assumes nothing of its surroundings.
package mslc_pkg;

  typedef logic [7:0] mslc_byte_t;

  // Write channel progress
  typedef enum logic [0:0] {
    MSLC_WR_COLLECT = 1'b0,
    MSLC_WR_RESP = 1'b1
  } mslc_wr_state_e;

endpackage

// ### hdl/mslc_pwm.sv
// Three-channel fan PWM generator with duty readback latched per PWM period.
// Assumes duty_in is already the effective duty (full duty forced upstream).
`timescale 1ns/1ps
`include "mslc_defs.svh"

module mslc_pwm (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [23:0] duty_in,
  output logic [2:0] pwm_out,
  output logic [23:0] duty_rb
);

  logic [7:0] cnt_ff;
  logic [7:0] nxt_cnt;
  logic cycle_end;

  // ----------------------------------------------------------------------------
  // Shared period counter
  // ----------------------------------------------------------------------------
  assign nxt_cnt = cnt_ff + 8'h01;
  assign cycle_end = (cnt_ff == 8'hff);

  // Period of 256 clocks
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_ff <= 8'h00;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  // ----------------------------------------------------------------------------
  // Per channel duty latch and output
  // ----------------------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < `MSLC_NUM_FANS; i = i + 1) begin : g_ch
      logic [7:0] duty_ff;
      logic pwm_ff;
      // New duty only at a period boundary, so no runt pulses
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          duty_ff <= `MSLC_FULL_DUTY;
          pwm_ff <= 1'b0;
        end else begin
          if (cycle_end) begin
            duty_ff <= duty_in[8*i +: 8];
          end
          pwm_ff <= (cnt_ff < duty_ff); // Duty ff: high 255, low 1
        end
      end
      assign pwm_out[i] = pwm_ff;
      assign duty_rb[8*i +: 8] = duty_ff;
    end
  endgenerate

endmodule

// ### hdl/mslc_startup.sv
// Start-up interval timer: reading valid only once the interval after run has passed.
// Assumes run is a registered level in the same clock domain.
`timescale 1ns/1ps
`include "mslc_defs.svh"

module mslc_startup #(
  parameter int unsigned CYCLES = `MSLC_STARTUP_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic run,
  output logic valid
);

  logic [23:0] cnt_ff;
  logic valid_ff;
  logic done;

  // ----------------------------------------------------------------------------
  // Count while running, restart on every stop
  // ----------------------------------------------------------------------------
  assign done = (cnt_ff >= 24'(CYCLES - 1));

  // Stop clears the interval so each restart waits the full time
  always_ff @(posedge aclk) begin
    if (!aresetn || !run) begin
      cnt_ff <= 24'h000000;
      valid_ff <= 1'b0;
    end else if (!valid_ff) begin
      cnt_ff <= cnt_ff + 24'h000001;
      valid_ff <= done; // Readings held invalid for the interval
    end
  end

  assign valid = valid_ff;

endmodule

// ### hdl/mslc_top.sv
// Monitor run/freeze control register bank with AXI4-Lite slave, fan PWM and readings.
// Assumes one 125 MHz clock, synchronous active-low reset acting as power-on reset,
// and inputs synchronous to aclk.
`timescale 1ns/1ps
`include "mslc_defs.svh"

module mslc_top #(
  parameter int unsigned STARTUP_CYCLES = `MSLC_STARTUP_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [23:0] auto_duty,
  input wire logic [7:0] sample_data,
  input wire logic sample_valid,
  input wire logic [3:0] limit_event,
  input wire logic [15:0] tach_count,
  output logic [2:0] pwm_out,
  output logic monitor_enable,
  output logic reading_valid,
  output logic [31:0] eff_limits
);

  // ----------------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------------
  mslc_pkg::mslc_wr_state_e wr_state_ff;
  logic aw_have_ff;
  logic w_have_ff;
  logic [7:0] aw_addr_ff;
  logic [7:0] w_data_ff;
  logic w_lane_ff;
  logic awready_ff;
  logic wready_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic arready_ff;
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;
  logic run_ff;
  logic freeze_ff;
  logic ready_ff;
  logic fan_full_override_ff;
  logic [2:0] fan_manual_ff;
  logic [31:0] limit_flat;
  logic [3:0] event_ff;
  mslc_pkg::mslc_byte_t reading_ff;
  logic monitor_enable_ff;
  logic [31:0] eff_limits_ff;
  logic [23:0] eff_duty;
  logic [23:0] duty_rb;
  logic aw_hs;
  logic w_hs;
  logic ar_hs;
  logic b_hs;
  logic r_hs;
  logic do_write;
  logic nxt_aw_have;
  logic nxt_w_have;
  logic nxt_bvalid;
  logic nxt_rvalid;
  logic wr_en;
  logic wr_ctrl;
  logic wr_fan_mode;
  logic wr_event;
  logic [3:0] wr_limit;
  logic [2:0] wr_duty;
  logic wr_mapped;
  logic [3:0] rd_limit_hit;
  logic [2:0] rd_duty_hit;
  logic [7:0] rd_limit_val;
  logic [7:0] rd_duty_val;
  logic rd_mapped;
  logic [31:0] rd_mux;
  logic [7:0] ctrl_rd;
  logic [3:0] nxt_event;

  // ----------------------------------------------------------------------------
  // AXI4-Lite handshakes
  // ----------------------------------------------------------------------------
  assign aw_hs = s_axi_awvalid & awready_ff;
  assign w_hs = s_axi_wvalid & wready_ff;
  assign b_hs = bvalid_ff & s_axi_bready;
  assign ar_hs = s_axi_arvalid & arready_ff;
  assign r_hs = rvalid_ff & s_axi_rready;
  assign do_write = aw_have_ff & w_have_ff & (wr_state_ff == mslc_pkg::MSLC_WR_COLLECT);
  assign nxt_aw_have = aw_hs | (aw_have_ff & ~do_write);
  assign nxt_w_have = w_hs | (w_have_ff & ~do_write);
  assign nxt_bvalid = do_write | (bvalid_ff & ~b_hs);
  assign nxt_rvalid = ar_hs | (rvalid_ff & ~r_hs);

  // Write address/data taken in either order, one write in flight
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state_ff <= mslc_pkg::MSLC_WR_COLLECT;
      aw_have_ff <= 1'b0;
      w_have_ff <= 1'b0;
      awready_ff <= 1'b0;
      wready_ff <= 1'b0;
      bvalid_ff <= 1'b0;
    end else begin
      aw_have_ff <= nxt_aw_have;
      w_have_ff <= nxt_w_have;
      bvalid_ff <= nxt_bvalid;
      awready_ff <= ~nxt_aw_have & ~nxt_bvalid;
      wready_ff <= ~nxt_w_have & ~nxt_bvalid;
      case (wr_state_ff)
        mslc_pkg::MSLC_WR_COLLECT: begin
          if (do_write) begin
            wr_state_ff <= mslc_pkg::MSLC_WR_RESP;
          end
        end
        mslc_pkg::MSLC_WR_RESP: begin
          if (b_hs) begin
            wr_state_ff <= mslc_pkg::MSLC_WR_COLLECT;
          end
        end
        default: begin
          wr_state_ff <= mslc_pkg::MSLC_WR_COLLECT;
        end
      endcase
    end
  end

  // Payload capture; only the low byte lane carries register data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_addr_ff <= 8'h00;
      w_data_ff <= 8'h00;
      w_lane_ff <= 1'b0;
      bresp_ff <= `MSLC_RESP_OKAY;
    end else begin
      if (aw_hs) begin
        aw_addr_ff <= s_axi_awaddr;
      end
      if (w_hs) begin
        w_data_ff <= s_axi_wdata[7:0];
        w_lane_ff <= s_axi_wstrb[0];
      end
      if (do_write) begin
        bresp_ff <= wr_mapped ? `MSLC_RESP_OKAY : `MSLC_RESP_SLVERR; // Frozen still OKAY
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------------------------
  assign wr_en = do_write & w_lane_ff;
  assign wr_ctrl = wr_en & (aw_addr_ff == `MSLC_OFS_CTRL);
  assign wr_fan_mode = wr_en & (aw_addr_ff == `MSLC_OFS_FAN_MODE);
  assign wr_event = wr_en & (aw_addr_ff == `MSLC_OFS_EVENT);

  // ----------------------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      run_ff <= 1'b0;
      freeze_ff <= 1'b0;
      ready_ff <= 1'b0;
      fan_full_override_ff <= 1'b0;
    end else begin
      ready_ff <= 1'b1; // Converters taken as ready one clock after reset
      if (wr_ctrl) begin
        run_ff <= w_data_ff[`MSLC_RUN_BIT]; // Not gated by freeze
        fan_full_override_ff <= w_data_ff[`MSLC_OVR_BIT];
        // Freeze only ever sets; only reset clears it
        freeze_ff <= freeze_ff | w_data_ff[`MSLC_FREEZE_BIT];
      end
    end
  end

  // Fan mode is a parameter register: frozen like the limits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fan_manual_ff <= `MSLC_FAN_MODE_RESET;
    end else if (wr_fan_mode && !freeze_ff) begin
      fan_manual_ff <= w_data_ff[2:0];
    end
  end

  // ----------------------------------------------------------------------------
  // Limit and manual duty registers
  // ----------------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < `MSLC_NUM_LIMITS; gi = gi + 1) begin : g_limit
      logic [7:0] limit_ff;
      assign wr_limit[gi] = wr_en &
        (aw_addr_ff == 8'(`MSLC_OFS_LIMIT0 + gi * `MSLC_OFS_LIMIT_STEP));
      assign rd_limit_hit[gi] =
        (s_axi_araddr == 8'(`MSLC_OFS_LIMIT0 + gi * `MSLC_OFS_LIMIT_STEP));
      // Run bit neither blocks nor alters these; freeze alone blocks
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          limit_ff <= `MSLC_LIMIT_DEFAULT;
        end else if (wr_limit[gi] && !freeze_ff) begin
          limit_ff <= w_data_ff;
        end
      end
      assign limit_flat[8*gi +: 8] = limit_ff;
    end
    for (gi = 0; gi < `MSLC_NUM_FANS; gi = gi + 1) begin : g_duty
      logic [7:0] duty_ff;
      assign wr_duty[gi] = wr_en &
        (aw_addr_ff == 8'(`MSLC_OFS_DUTY0 + gi * `MSLC_OFS_DUTY_STEP));
      assign rd_duty_hit[gi] =
        (s_axi_araddr == 8'(`MSLC_OFS_DUTY0 + gi * `MSLC_OFS_DUTY_STEP));
      // Manual duty taken only while running, unfrozen, manual mode
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          duty_ff <= `MSLC_FULL_DUTY;
        end else if (wr_duty[gi] && run_ff && !freeze_ff && fan_manual_ff[gi]) begin
          duty_ff <= w_data_ff;
        end
      end
      // Stop or override wins over manual and automatic duty
      assign eff_duty[8*gi +: 8] = (!run_ff || fan_full_override_ff) ? `MSLC_FULL_DUTY :
        (fan_manual_ff[gi] ? duty_ff : auto_duty[8*gi +: 8]);
    end
  endgenerate

  // ----------------------------------------------------------------------------
  // Monitoring state
  // ----------------------------------------------------------------------------
  // Status bits: set wins over write-one clear, sets only while running
  assign nxt_event = (event_ff & ~(wr_event ? w_data_ff[3:0] : 4'h0)) |
    (run_ff ? limit_event : 4'h0);

  // Readings and effective limits follow the run bit
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      event_ff <= 4'h0;
      reading_ff <= 8'h00;
      monitor_enable_ff <= 1'b0;
      eff_limits_ff <= {`MSLC_NUM_LIMITS{`MSLC_LIMIT_DEFAULT}};
    end else begin
      event_ff <= nxt_event;
      if (run_ff && sample_valid) begin
        reading_ff <= sample_data; // Frozen while stopped
      end
      monitor_enable_ff <= run_ff;
      // Defaults while stopped, programmed values once running
      eff_limits_ff <= run_ff ? limit_flat : {`MSLC_NUM_LIMITS{`MSLC_LIMIT_DEFAULT}};
    end
  end

  mslc_startup #(
    .CYCLES(STARTUP_CYCLES)
  ) u_startup (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(run_ff),
    .valid(reading_valid)
  );

  mslc_pwm u_pwm (
    .aclk(aclk),
    .aresetn(aresetn),
    .duty_in(eff_duty),
    .pwm_out(pwm_out),
    .duty_rb(duty_rb)
  );

  // ----------------------------------------------------------------------------
  // Read decode and mux
  // ----------------------------------------------------------------------------
  assign ctrl_rd = {4'h0, fan_full_override_ff, ready_ff, freeze_ff, run_ff};
  assign rd_limit_val = rd_limit_hit[0] ? limit_flat[7:0] :
    rd_limit_hit[1] ? limit_flat[15:8] :
    rd_limit_hit[2] ? limit_flat[23:16] : limit_flat[31:24];
  assign rd_duty_val = rd_duty_hit[0] ? duty_rb[7:0] :
    rd_duty_hit[1] ? duty_rb[15:8] : duty_rb[23:16];
  assign rd_mapped = (|rd_limit_hit) | (|rd_duty_hit) |
    (s_axi_araddr == `MSLC_OFS_CTRL) | (s_axi_araddr == `MSLC_OFS_FAN_MODE) |
    (s_axi_araddr == `MSLC_OFS_STATUS) | (s_axi_araddr == `MSLC_OFS_EVENT) |
    (s_axi_araddr == `MSLC_OFS_READING) | (s_axi_araddr == `MSLC_OFS_TACH);
  assign wr_mapped = (|wr_limit) | (|wr_duty) | wr_ctrl | wr_fan_mode | wr_event |
    (aw_addr_ff == `MSLC_OFS_STATUS) | (aw_addr_ff == `MSLC_OFS_READING) |
    (aw_addr_ff == `MSLC_OFS_TACH) | ~w_lane_ff;
  assign rd_mux =
    (|rd_limit_hit) ? {24'h000000, rd_limit_val} :
    (|rd_duty_hit) ? {24'h000000, rd_duty_val} :
    (s_axi_araddr == `MSLC_OFS_CTRL) ? {24'h000000, ctrl_rd} :
    (s_axi_araddr == `MSLC_OFS_FAN_MODE) ? {29'h00000000, fan_manual_ff} :
    (s_axi_araddr == `MSLC_OFS_STATUS) ? {30'h00000000, freeze_ff, reading_valid} :
    (s_axi_araddr == `MSLC_OFS_EVENT) ? {28'h0000000, event_ff} :
    (s_axi_araddr == `MSLC_OFS_READING) ? {24'h000000, reading_ff} :
    (s_axi_araddr == `MSLC_OFS_TACH) ? {16'h0000, tach_count} : // Always live
    32'h00000000;

  // Read answer one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
      rresp_ff <= `MSLC_RESP_OKAY;
    end else begin
      rvalid_ff <= nxt_rvalid;
      arready_ff <= ~nxt_rvalid;
      if (ar_hs) begin
        rdata_ff <= rd_mux;
        rresp_ff <= rd_mapped ? `MSLC_RESP_OKAY : `MSLC_RESP_SLVERR;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------------
  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
  assign monitor_enable = monitor_enable_ff;
  assign eff_limits = eff_limits_ff;

endmodule

// ### sim/monitor_start_lock_control_bench.sv
// Self-checking bench for the monitor run/freeze control block, with a register model.
// Assumes the design and checker files are compiled ahead of it; one 125 MHz clock.
`timescale 1ns/1ps

module monitor_start_lock_control_bench;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, sample_valid;
  logic monitor_enable, reading_valid, run, frz, ovr;
  logic [7:0] s_axi_awaddr, s_axi_araddr, sample_data, mduty, rdg;
  logic [2:0] s_axi_awprot, s_axi_arprot, pwm_out, mode;
  logic [31:0] s_axi_wdata, s_axi_rdata, eff_limits;
  logic [3:0] s_axi_wstrb, limit_event, ev;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [23:0] auto_duty;
  logic [15:0] tach_count;
  logic [7:0] lim [4];
  int failures, cmp_count, seed, i;

  always #4 aclk = ~aclk;

  mslc_top #(.STARTUP_CYCLES(20)) u_mslc_top (.*);

  // ---------------------------------------------------------------------------
  // Model and helpers
  // ---------------------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic tmo();
    failures++;
    print_verdict();
  endtask

  task automatic mrst();
    run = 0;
    frz = 0;
    ovr = 0;
    mode = 3'h0;
    ev = 4'h0;
    mduty = 8'h00;
    rdg = 8'h00;
    for (int k = 0; k < 4; k++) lim[k] = 8'h7f;
  endtask

  // Duty a fan should show: stop and override force full duty
  function automatic logic [7:0] eff(input int f);
    if (!run || ovr) return 8'hff;
    if (f == 0 && mode[0]) return mduty;
    return auto_duty[8 * f +: 8];
  endfunction

  function automatic logic [31:0] mrd(input logic [7:0] a);
    if (a >= 8'h84 && a <= 8'h90) return {24'h0, lim[(a - 8'h84) >> 2]};
    case (a)
      8'h30: return {24'h0, eff(0)};
      8'h40: return {28'h0, ovr, 1'b1, frz, run};
      8'h80: return {29'h0, mode};
      8'ha4: return {28'h0, ev};
      8'ha8: return {24'h0, rdg};
      8'hac: return {16'h0, tach_count};
      default: return 32'h0;
    endcase
  endfunction

  // Freeze only ever sets; stopped or frozen duty writes are dropped
  task automatic mwr(input logic [7:0] a, input logic [31:0] d);
    if (a >= 8'h84 && a <= 8'h90 && !frz) lim[(a - 8'h84) >> 2] = d[7:0];
    if (a == 8'h80 && !frz) mode = d[2:0];
    if (a == 8'ha4) ev &= ~d[3:0];
    if (a == 8'h30 && run && !frz && mode[0]) mduty = d[7:0];
    if (a == 8'h40) begin
      run = d[0];
      frz |= d[1];
      ovr = d[3];
    end
  endtask

  // Bus write; bready raised only after bvalid so the response hold is exercised
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) break;
      if (s_axi_bvalid) s_axi_bready <= 1'b1;
    end
    s_axi_bready <= 1'b0;
    if (n == 64) tmo();
    chk("bresp", {30'h0, s_axi_bresp}, (a[7:6] == 2'b11) ? 32'h2 : 32'h0);
    mwr(a, d);
  endtask

  task automatic rd(input logic [7:0] a);
    int n;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) break;
      if (s_axi_rvalid) s_axi_rready <= 1'b1;
    end
    s_axi_rready <= 1'b0;
    if (n == 64) tmo();
    chk("rdata", s_axi_rdata, mrd(a));
    chk("rresp", {30'h0, s_axi_rresp}, (a[7:6] == 2'b11) ? 32'h2 : 32'h0);
  endtask

  // Sample and event pulse; the model only takes them while running
  task automatic ping(input logic [7:0] d, input logic [3:0] e);
    sample_data <= d;
    sample_valid <= 1'b1;
    limit_event <= e;
    @(posedge aclk);
    sample_valid <= 1'b0;
    limit_event <= 4'h0;
    if (run) begin
      ev |= e;
      rdg = d;
    end
  endtask

  // Low clocks over two PWM periods, after the new duty has reached the pins
  task automatic pw();
    int lows, want, f;
    lows = 0;
    want = 0;
    repeat (300) @(posedge aclk);
    for (f = 0; f < 3; f++) want += 2 * (256 - eff(f));
    repeat (512) begin
      @(posedge aclk);
      for (f = 0; f < 3; f++) if (pwm_out[f] === 1'b0) lows++;
    end
    chk("pwm_lows", lows, want);
  endtask

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    {aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 6'h0;
    {s_axi_rready, sample_valid, s_axi_awaddr, s_axi_araddr, sample_data} = 26'h0;
    {s_axi_awprot, s_axi_arprot, s_axi_wdata, limit_event, auto_duty} = 66'h0;
    s_axi_wstrb = 4'hf;
    tach_count = 16'h0;
    failures = 0;
    cmp_count = 0;
    seed = 34;
    mrst();
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rd(8'h40);
    rd(8'h84);
    rd(8'hfc);
    wr(8'hfc, 32'hff);
    rd(8'h30);
    tach_count <= 16'($random(seed));
    ping(8'($random(seed)), 4'hf);
    rd(8'hac);
    rd(8'ha4);
    for (i = 0; i < 4; i++) begin
      wr(8'h84 + 8'(4 * i), $random(seed));
      rd(8'h84 + 8'(4 * i));
    end
    chk("eff_limits", eff_limits, 32'h7f7f7f7f);
    pw();
    wr(8'h40, 32'h1);
    chk("monitor_enable", monitor_enable, run);
    chk("reading_valid", {31'h0, reading_valid}, 32'h0);
    repeat (30) @(posedge aclk);
    chk("reading_valid", {31'h0, reading_valid}, 32'h1);
    chk("eff_limits", eff_limits, {lim[3], lim[2], lim[1], lim[0]});
    ping(8'($random(seed)), 4'h5);
    rd(8'ha8);
    rd(8'ha4);
    wr(8'ha4, 32'h1);
    rd(8'ha4);
    auto_duty <= 24'($random(seed));
    pw();
    wr(8'h88, $random(seed));
    rd(8'h88);
    wr(8'h80, 32'h1);
    wr(8'h30, 32'h40);
    pw();
    rd(8'h30);
    wr(8'h40, 32'h0);
    repeat (3) @(posedge aclk);
    chk("monitor_enable", monitor_enable, run);
    chk("eff_limits", eff_limits, 32'h7f7f7f7f);
    for (i = 0; i < 4; i++) rd(8'h84 + 8'(4 * i));
    ping(8'($random(seed)), 4'hf);
    rd(8'ha8);
    rd(8'ha4);
    wr(8'h30, 32'h10);
    pw();
    wr(8'h40, 32'h3);
    wr(8'h84, $random(seed));
    rd(8'h84);
    wr(8'h80, 32'h0);
    rd(8'h80);
    wr(8'h30, 32'h20);
    pw();
    rd(8'h30);
    wr(8'h40, 32'h0);
    rd(8'h40);
    wr(8'h40, 32'h9);
    pw();
    rd(8'h40);
    aresetn <= 1'b0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    mrst();
    repeat (2) @(posedge aclk);
    rd(8'h40);
    rd(8'h84);
    print_verdict();
  end
endmodule

// ### sim/mslc_sva.sv
// Checker for the monitor run/freeze control block: bus timing, stop defaults, PWM, start-up.
// Assumes it is bound to mslc_top and sees only that module's ports.
`timescale 1ns/1ps

module mslc_sva #(
  parameter int unsigned STARTUP_CYCLES = 20
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [2:0] pwm_out,
  input wire logic monitor_enable,
  input wire logic reading_valid,
  input wire logic [31:0] eff_limits
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // ---------------------------------------------------------------------------
  // Helper state
  // ---------------------------------------------------------------------------
  logic [7:0] rd_addr_ff;
  logic [9:0] stop_cnt_ff;
  logic [31:0] run_cnt_ff;
  logic [7:0] nxt_rd_addr;
  logic [9:0] nxt_stop_cnt;
  logic [31:0] nxt_run_cnt;
  logic stop_long;

  // Stop counter saturates: full duty only guaranteed once the PWM period wrapped
  assign stop_long = stop_cnt_ff == 10'h12c && !monitor_enable;
  assign nxt_stop_cnt = monitor_enable ? 10'h000 : (stop_long ? stop_cnt_ff : stop_cnt_ff + 10'h1);
  assign nxt_run_cnt = monitor_enable ? run_cnt_ff + 32'h1 : 32'h0;
  assign nxt_rd_addr = (s_axi_arvalid && s_axi_arready) ? s_axi_araddr : rd_addr_ff;

  // Registers of the helpers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_addr_ff <= 8'h00;
      stop_cnt_ff <= 10'h000;
      run_cnt_ff <= 32'h0;
    end else begin
      rd_addr_ff <= nxt_rd_addr;
      stop_cnt_ff <= nxt_stop_cnt;
      run_cnt_ff <= nxt_run_cnt;
    end
  end

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_b_late;
    !s_axi_bvalid ##1 s_axi_bvalid;
  endsequence

  a_wr_answer: assert property (s_wr_taken |=> s_b_late)
    else $error("write response not two cycles after handshake");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before accepted");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before accepted");
  a_ctrl_read: assert property (s_axi_rvalid && rd_addr_ff == 8'h40 |->
    s_axi_rdata[31:4] == 28'h0 && s_axi_rdata[2])
    else $error("control read bad ready or reserved bits");
  a_unmapped_rd: assert property (s_axi_rvalid && rd_addr_ff[7:6] == 2'b11 |->
    s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  a_stop_limits: assert property (!monitor_enable && !$past(monitor_enable) |->
    eff_limits == 32'h7f7f7f7f)
    else $error("stopped block uses programmed limits");
  a_valid_stop: assert property (!monitor_enable && !$past(monitor_enable) |->
    !reading_valid)
    else $error("reading valid while stopped");
  a_valid_rise: assert property ($rose(reading_valid) |->
    run_cnt_ff + 32'h3 >= STARTUP_CYCLES && run_cnt_ff <= STARTUP_CYCLES + 2)
    else $error("reading valid at wrong time after start");
  a_pwm_low: assert property (stop_long && !pwm_out[0] |=> pwm_out[0])
    else $error("stopped fan low longer than one clock");
  a_pwm_period: assert property (stop_long && $fell(pwm_out[1]) |-> ##256 !pwm_out[1])
    else $error("stopped fan period not 256 clocks");
endmodule

bind mslc_top mslc_sva #(.STARTUP_CYCLES(STARTUP_CYCLES)) u_mslc_sva (.aclk, .aresetn,
  .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
  .s_axi_rready, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .pwm_out, .monitor_enable, .reading_valid, .eff_limits);
